// file: verilog/swa_pkg.sv
package swa_pkg;
    localparam int FLAG_COUNT = 24;
    localparam int SEL_WIDTH = 4;
    localparam int COARSE_WIDTH = 8;
    localparam int FINE_WIDTH = 8;
    localparam int CFG_WIDTH = 8;
    localparam int RESULT_WIDTH = 1 + COARSE_WIDTH + FINE_WIDTH;
    localparam logic [2:0] VALID_EDGES = 3'h3;
    localparam logic [11:0] ADDR_FLAGS_LOW = 12'h02E;
    localparam logic [11:0] ADDR_FLAGS_MID = 12'h02F;
    localparam logic [11:0] ADDR_FLAGS_HIGH = 12'h030;
    localparam logic [11:0] ADDR_ALIGN_STATUS = 12'h031;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 24'hFFFFFF;
    localparam logic [COARSE_WIDTH-1:0] COARSE_MAX = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [2:0] {
        SWA_IDLE = 3'b000,
        SWA_SETTLE = 3'b001,
        SWA_WAIT_EDGE = 3'b010,
        SWA_JUDGE = 3'b011,
        SWA_DONE = 3'b100
    } swa_state_t;
endpackage

// file: verilog/swa_sysref_align.sv
//Contract
//- SYSREF is captured on a fixed, deterministic device clock edge at every start.
//- Single-channel mode samples on both clock edges, doubling the SYSREF window.
//- Phase flags report SYSREF position; valid only after three SYSREF rising edges.
//- A flag of 1 marks a setup or hold risk; 0 marks a safe position.
//- Twenty-four flag positions; bits 0 and 23 always read 1.
//- Phase select picks one of the first sixteen positions only.
//- The fine-step control chooses finer detector delay steps when set.
//- Once enabled, search clock delays until clock falling edge meets SYSREF rise.
//- Done flag is raised when the search has finished.
//- Found delay is reported and applied until alignment is disabled and overridden.
//- The search tries coarse delays with both clock polarities, keeping the smaller.
//- The half-period invert delays all internal clocks by half a period.
`timescale 1ns/100ps
`default_nettype none
module swa_sysref_align
    import swa_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Delayed SYSREF samples, one per candidate position, from the delay line
    input wire logic [FLAG_COUNT-1:0] sysref_tap,
    // Falling edge of the internal clock lies at or after the SYSREF rising edge
    input wire logic clock_edge_reached,
    // Mode and software controls
    input wire logic single_channel_mode,
    input wire logic phase_step_fine,
    input wire logic [SEL_WIDTH-1:0] capture_phase_select,
    input wire logic autoalign_enable,
    input wire logic [CFG_WIDTH-1:0] autoalign_config,
    input wire logic manual_half_period_invert,
    input wire logic [COARSE_WIDTH-1:0] manual_delay_coarse,
    input wire logic [FINE_WIDTH-1:0] manual_delay_fine,
    // Register read port
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    output logic [7:0] reg_rdata,
    // Status
    output logic [FLAG_COUNT-1:0] capture_phase_flags,
    output logic flags_valid,
    output logic sysref_captured,
    output logic autoalign_done,
    output logic [RESULT_WIDTH-1:0] autoalign_result_delay,
    // Controls to the clock path
    output logic dual_edge_sampling,
    output logic detector_step_fine,
    output logic clock_half_period_invert,
    output logic [COARSE_WIDTH-1:0] clock_delay_coarse,
    output logic [FINE_WIDTH-1:0] clock_delay_fine
);
    swa_state_t state_q, state_d;
    logic tap0_prev_q;
    logic [2:0] edge_cnt_q;
    logic valid_q;
    logic [FLAG_COUNT-1:0] flags_q;
    logic captured_q;
    logic done_q;
    logic [RESULT_WIDTH-1:0] result_q;
    logic polarity_q;
    logic [COARSE_WIDTH-1:0] coarse_q;
    logic [COARSE_WIDTH-1:0] best0_q;
    logic [CFG_WIDTH-1:0] settle_q;
    logic inv_q;
    logic [COARSE_WIDTH-1:0] dly_coarse_q;
    logic [FINE_WIDTH-1:0] dly_fine_q;
    logic [7:0] rdata_q;
    logic dual_q;
    logic fine_q;

    wire logic sysref_rise = sysref_tap[0] & ~tap0_prev_q;
    wire logic [FLAG_COUNT-1:0] flags_new;
    wire logic judge_hit = clock_edge_reached || (coarse_q == COARSE_MAX);
    wire logic pick_inverted = polarity_q && (coarse_q < best0_q);
    wire logic [COARSE_WIDTH-1:0] best_coarse = pick_inverted ? coarse_q : best0_q;

    // Edge positions lack a neighbour on one side, so they are always flagged
    assign flags_new[0] = 1'b1;
    assign flags_new[FLAG_COUNT-1] = 1'b1;
    genvar g;
    generate
        for (g = 1; g < FLAG_COUNT - 1; g = g + 1) begin : g_flag
            // A neighbour sampling differently means SYSREF moves near this position
            assign flags_new[g] = (sysref_tap[g] != sysref_tap[g-1]) || (sysref_tap[g] != sysref_tap[g+1]);
        end
    endgenerate

    wire logic [7:0] rd_mux =
        (reg_addr == ADDR_FLAGS_LOW) ? flags_q[7:0] :
        (reg_addr == ADDR_FLAGS_MID) ? flags_q[15:8] :
        (reg_addr == ADDR_FLAGS_HIGH) ? flags_q[23:16] :
        (reg_addr == ADDR_ALIGN_STATUS) ? {6'h00, valid_q, done_q} :
        READ_UNMAPPED;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SWA_IDLE: begin
                if (autoalign_enable) begin
                    state_d = SWA_SETTLE;
                end
            end
            SWA_SETTLE: begin
                if (settle_q == '0) begin
                    state_d = SWA_WAIT_EDGE;
                end
            end
            SWA_WAIT_EDGE: begin
                // Judge only right after a fresh SYSREF edge under the new delay
                if (sysref_rise) begin
                    state_d = SWA_JUDGE;
                end
            end
            SWA_JUDGE: begin
                if (judge_hit && polarity_q) begin
                    state_d = SWA_DONE;
                end else begin
                    state_d = SWA_SETTLE;
                end
            end
            SWA_DONE: begin
                state_d = SWA_DONE;
            end
            default: begin
                state_d = SWA_IDLE;
            end
        endcase
        if (!autoalign_enable) begin
            state_d = SWA_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q <= SWA_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tap0_prev_q <= 1'b0;
            edge_cnt_q <= 3'h0;
            valid_q <= 1'b0;
            flags_q <= FLAGS_RESET;
        end else begin
            tap0_prev_q <= sysref_tap[0];
            if (sysref_rise) begin
                flags_q <= flags_new;
                if (edge_cnt_q != VALID_EDGES) begin
                    edge_cnt_q <= edge_cnt_q + 3'h1;
                end
                // Registered so the status pin rises on the same edge as the third count
                if (edge_cnt_q == VALID_EDGES - 3'h1) begin
                    valid_q <= 1'b1;
                end
            end
        end
    end

    // Select width of four bits limits the choice to positions 0..15
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            captured_q <= 1'b0;
        end else begin
            captured_q <= sysref_tap[capture_phase_select];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dual_q <= 1'b0;
            fine_q <= 1'b0;
        end else begin
            dual_q <= single_channel_mode;
            fine_q <= phase_step_fine;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            settle_q <= '0;
        end else if (state_q == SWA_IDLE || state_q == SWA_JUDGE) begin
            settle_q <= autoalign_config;
        end else if (state_q == SWA_SETTLE && settle_q != '0) begin
            settle_q <= settle_q - 8'h01;
        end
    end

    // Search walks coarse delay upward first without, then with inversion
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            polarity_q <= 1'b0;
            coarse_q <= '0;
            best0_q <= COARSE_MAX;
            done_q <= 1'b0;
            result_q <= '0;
        end else if (state_q == SWA_IDLE || !autoalign_enable) begin
            // Done must fall on the edge that sees enable low, not one later in idle
            polarity_q <= 1'b0;
            coarse_q <= '0;
            best0_q <= COARSE_MAX;
            done_q <= 1'b0;
        end else if (state_q == SWA_JUDGE) begin
            if (judge_hit && !polarity_q) begin
                best0_q <= coarse_q;
                polarity_q <= 1'b1;
                coarse_q <= '0;
            end else if (judge_hit) begin
                done_q <= 1'b1;
                result_q <= {pick_inverted, best_coarse, {FINE_WIDTH{1'b0}}};
            end else begin
                coarse_q <= coarse_q + 8'h01;
            end
        end
    end

    // Applied delay: search trial, then found value, else manual override
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            inv_q <= 1'b0;
            dly_coarse_q <= '0;
            dly_fine_q <= '0;
        end else if (!autoalign_enable) begin
            inv_q <= manual_half_period_invert;
            dly_coarse_q <= manual_delay_coarse;
            dly_fine_q <= manual_delay_fine;
        end else if (state_q == SWA_DONE) begin
            {inv_q, dly_coarse_q, dly_fine_q} <= result_q;
        end else begin
            inv_q <= polarity_q;
            dly_coarse_q <= coarse_q;
            dly_fine_q <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;
    assign capture_phase_flags = flags_q;
    assign flags_valid = valid_q;
    assign sysref_captured = captured_q;
    assign autoalign_done = done_q;
    assign autoalign_result_delay = result_q;
    assign dual_edge_sampling = dual_q;
    assign detector_step_fine = fine_q;
    assign clock_half_period_invert = inv_q;
    assign clock_delay_coarse = dly_coarse_q;
    assign clock_delay_fine = dly_fine_q;
endmodule
`default_nettype wire

// file: sim/swa_sysref_align_props.sv
`timescale 1ns/100ps
`default_nettype none
module swa_sysref_align_props
    import swa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [FLAG_COUNT-1:0] sysref_tap,
    input wire logic single_channel_mode,
    input wire logic [SEL_WIDTH-1:0] capture_phase_select,
    input wire logic autoalign_enable,
    input wire logic [FLAG_COUNT-1:0] capture_phase_flags,
    input wire logic flags_valid,
    input wire logic sysref_captured,
    input wire logic autoalign_done,
    input wire logic [RESULT_WIDTH-1:0] autoalign_result_delay,
    input wire logic dual_edge_sampling,
    input wire logic clock_half_period_invert,
    input wire logic [COARSE_WIDTH-1:0] clock_delay_coarse,
    input wire logic [FINE_WIDTH-1:0] clock_delay_fine
);
    logic prev_q;
    logic [1:0] rise_q;
    wire logic rise = sysref_tap[0] && !prev_q;
    // Risk where a tap disagrees with a neighbour; the two end taps cannot be judged
    wire logic [FLAG_COUNT-1:0] nb = (sysref_tap ^ (sysref_tap << 1)) | (sysref_tap ^ (sysref_tap >> 1)) | 24'h800001;
    wire logic [RESULT_WIDTH-1:0] applied = {clock_half_period_invert, clock_delay_coarse, clock_delay_fine};
    always_ff @(posedge ref_clk) begin
        prev_q <= resetn ? sysref_tap[0] : 1'b0;
        rise_q <= !resetn ? 2'h0 : (rise && rise_q != 2'h3) ? rise_q + 2'h1 : rise_q;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_flag_ends: assert property (capture_phase_flags[0] && capture_phase_flags[FLAG_COUNT-1])
        else $error("end flags not set");
    a_flags_update: assert property (rise |=> capture_phase_flags == $past(nb))
        else $error("flags not taken from taps");
    a_valid_early: assert property (rise_q != 2'h3 |-> !flags_valid)
        else $error("flags valid too early");
    a_valid_held: assert property (flags_valid |=> flags_valid)
        else $error("flags valid dropped");
    a_dual_edge: assert property ($past(resetn) |-> dual_edge_sampling == $past(single_channel_mode))
        else $error("dual edge mode wrong");
    a_capture_sel: assert property ($past(resetn) |-> sysref_captured == $past(sysref_tap[capture_phase_select]))
        else $error("wrong capture position");
    a_done_cleared: assert property (!autoalign_enable |=> !autoalign_done)
        else $error("done while disabled");
    a_done_held: assert property (autoalign_done && autoalign_enable |=> autoalign_done)
        else $error("done dropped");
    a_search_time: assert property ($rose(autoalign_enable) |=> !autoalign_done [*3])
        else $error("done without search");
    a_result_fine: assert property (autoalign_done |-> autoalign_result_delay[FINE_WIDTH-1:0] == 8'h00)
        else $error("result fine not zero");
    a_result_applied: assert property (autoalign_done && $past(autoalign_done) |-> applied == autoalign_result_delay)
        else $error("result not applied");
    cover property (rise_q == 2'h3);
    cover property ($rose(autoalign_done));
    cover property (autoalign_done && clock_half_period_invert);
endmodule
bind swa_sysref_align swa_sysref_align_props u_props (.ref_clk, .resetn, .sysref_tap, .single_channel_mode,
    .capture_phase_select, .autoalign_enable, .capture_phase_flags, .flags_valid, .sysref_captured, .autoalign_done,
    .autoalign_result_delay, .dual_edge_sampling, .clock_half_period_invert, .clock_delay_coarse, .clock_delay_fine);
`default_nettype wire

// file: sim/swa_clk_source.sv
`timescale 1ns/100ps
`default_nettype none
module swa_clk_source
    import swa_pkg::*;
#(
    parameter int HIT_PLAIN = 40,
    parameter int HIT_INV = 12
)(
    input wire logic ref_clk,
    input wire logic [4:0] edge_pos,
    input wire logic clock_half_period_invert,
    input wire logic [COARSE_WIDTH-1:0] clock_delay_coarse,
    output logic [FLAG_COUNT-1:0] sysref_tap,
    output logic clock_edge_reached
);
    logic [3:0] phase_q = 4'h0;
    // Periodic and never stopped, since the alignment search needs a steady reference
    always @(posedge ref_clk) begin
        phase_q <= phase_q + 4'h1;
    end
    // Early taps see the rise a cycle before late ones
    assign sysref_tap = phase_q == 4'h8 ? 24'hFFFFFF >> (5'd23 - edge_pos) : phase_q > 4'h8 ? 24'hFFFFFF : 24'h000000;
    // Inverted clock needs less coarse delay to reach the edge
    assign clock_edge_reached = clock_delay_coarse >= (clock_half_period_invert ? 8'(HIT_INV) : 8'(HIT_PLAIN));
endmodule
`default_nettype wire

// file: sim/sysref_window_autoalign_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sysref_window_autoalign_tb
    import swa_pkg::*;
;
    localparam int HIT_PLAIN = 40;
    localparam int HIT_INV = 12;
    logic ref_clk = 1'b0, resetn = 1'b0, single_channel_mode = 1'b0, phase_step_fine = 1'b0;
    logic autoalign_enable = 1'b0, manual_half_period_invert = 1'b0, reg_rd = 1'b0, tap_prev = 1'b0;
    logic [SEL_WIDTH-1:0] capture_phase_select = 4'h0;
    logic [7:0] autoalign_config = 8'h00, manual_delay_coarse = 8'h00, manual_delay_fine = 8'h00;
    logic [11:0] reg_addr = 12'h000;
    logic [4:0] edge_pos = 5'h0A;
    logic [7:0] reg_rdata, clock_delay_coarse, clock_delay_fine;
    logic [FLAG_COUNT-1:0] sysref_tap, capture_phase_flags;
    logic clock_edge_reached, flags_valid, sysref_captured, autoalign_done;
    logic dual_edge_sampling, detector_step_fine, clock_half_period_invert;
    logic [RESULT_WIDTH-1:0] autoalign_result_delay;
    int fails = 0, samples_checked = 0, rises = 0;
    swa_clk_source #(.HIT_PLAIN(HIT_PLAIN), .HIT_INV(HIT_INV)) u_src (.ref_clk, .edge_pos,
        .clock_half_period_invert, .clock_delay_coarse, .sysref_tap, .clock_edge_reached);
    swa_sysref_align uut (.ref_clk, .resetn, .sysref_tap, .clock_edge_reached, .single_channel_mode, .phase_step_fine,
        .capture_phase_select, .autoalign_enable, .autoalign_config, .manual_half_period_invert, .manual_delay_coarse,
        .manual_delay_fine, .reg_rd, .reg_addr, .reg_rdata, .capture_phase_flags, .flags_valid, .sysref_captured,
        .autoalign_done, .autoalign_result_delay, .dual_edge_sampling, .detector_step_fine, .clock_half_period_invert,
        .clock_delay_coarse, .clock_delay_fine);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (!resetn) rises = 0;
        else if (sysref_tap[0] && !tap_prev) rises = rises + 1;
        tap_prev = sysref_tap[0];
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [11:0] addr, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = addr;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        check("reg_rdata", {16'h0000, exp}, {16'h0000, reg_rdata});
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_detect;
        check("flags", FLAGS_RESET, capture_phase_flags);
        rd(12'h100, READ_UNMAPPED);
        repeat (60) begin
            @(negedge ref_clk);
            check("flags_valid", {23'h0, rises >= 3}, {23'h0, flags_valid});
        end
        check("flags", 24'h800C01, capture_phase_flags);
        rd(ADDR_FLAGS_LOW, 8'h01);
        rd(ADDR_FLAGS_MID, 8'h0C);
        rd(ADDR_FLAGS_HIGH, 8'h80);
        rd(ADDR_ALIGN_STATUS, 8'h02);
        edge_pos = 5'h05;
        repeat (17) @(negedge ref_clk);
        check("flags", 24'h800061, capture_phase_flags);
        single_channel_mode = 1'b1;
        phase_step_fine = 1'b1;
        // Middle of the safe stretch between flagged positions 6 and 23
        capture_phase_select = 4'hE;
        repeat (2) @(negedge ref_clk);
        check("modes", 24'h3, {22'h0, dual_edge_sampling, detector_step_fine});
    endtask
    task automatic t_align;
        int n;
        capture_phase_select = 4'h0;
        autoalign_config = 8'h02;
        @(negedge ref_clk);
        // No converter calibration exists in this bench, so the search may start
        autoalign_enable = 1'b1;
        n = 0;
        while (autoalign_done !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 3000) begin
            fails++;
            $display("Error autoalign_done expected 1 seen %b", autoalign_done);
            stop_test();
        end
        check("result", {7'h0, 1'b1, 8'(HIT_INV), 8'h00}, {7'h0, autoalign_result_delay});
        rd(ADDR_ALIGN_STATUS, 8'h03);
        check("applied", {7'h0, 1'b1, 8'(HIT_INV), 8'h00}, {7'h0, clock_half_period_invert, clock_delay_coarse, clock_delay_fine});
        manual_delay_coarse = 8'h22;
        manual_delay_fine = 8'h33;
        autoalign_enable = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("done", 24'h0, {23'h0, autoalign_done});
        check("manual", 24'h2233, {7'h0, clock_half_period_invert, clock_delay_coarse, clock_delay_fine});
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        t_detect();
        t_align();
        stop_test();
    end
endmodule
`default_nettype wire
